/* File: dv/hfct_core_bench.sv */
// Self-checking bench for the host data core.
// Assumes the checker and the receive model are compiled before it.
module hfct_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import hfct_pkg::*;
  logic        clk, nrst, host_wr, host_rd, queue_clear, eng_rd, rx_byte_valid, rx_byte_first;
  logic        rx_frame_end, len_check_en, len_reject, tx_eof_start, crc_high_bit_leading;
  logic        checksum_complete, irq_any, irq_out, tick_divider_even, tick_periodic, tick_go;
  logic        tick_halt, tick_auto_launch, tick_active, queue_overrun, queue_nearly_full;
  logic        queue_nearly_empty, rx_go, rx_busy, ok;
  logic [7:0]  host_wdata, host_rdata, eng_rdata, rx_byte, error_flags, crc_result_hi, d0, d1;
  logic [7:0]  crc_result_lo, irq_enable_mask, irq_flag_set, irq_flag_clr, irq_flags, rx_len;
  logic [5:0]  queue_threshold, frame_len_floor, frame_len_ceiling;
  logic [6:0]  queue_fill_count;
  logic [3:0]  cmd_select;
  logic [1:0]  crc_seed_sel;
  logic [11:0] tick_divider;
  logic [15:0] tick_reload_value, tick_current_count;
  logic [31:0] seed = 32'h00007F82;
  logic [19:0] tbl [7] = '{20'h1050F, 20'h10510, 20'h10513, 20'h10514, 20'h24023, 20'h240FF,
                           20'hFC100};
  logic [7:0]  q [$];
  logic [7:0]  last;
  int          miscompares = 0;
  int          comparisons = 0;
  int          n, want;
  hfct_core hfct_core_i (.*);
  hfct_rx_model hfct_rx_model_i (.clk(clk), .go(rx_go), .len(rx_len), .busy(rx_busy),
    .rx_byte_valid(rx_byte_valid), .rx_byte_first(rx_byte_first), .rx_byte(rx_byte),
    .rx_frame_end(rx_frame_end));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // m[2] selects high bit first, m[1:0] the seed
  function automatic logic [15:0] crcf(input logic [2:0] m, input logic [7:0] a, b);
    logic [15:0] c;
    c = (m[1:0] == 2'h0) ? 16'h0000 : (m[1:0] == 2'h1) ? 16'h6363 :
        (m[1:0] == 2'h2) ? 16'hA671 : 16'hFFFF;
    for (int k = 0; k < 2; k++) begin
      c = m[2] ? c ^ {(k ? b : a), 8'h00} : c ^ {8'h00, (k ? b : a)};
      for (int j = 0; j < 8; j++)
        c = m[2] ? (c[15] ? (c << 1) ^ CRC_POLY_MSB : c << 1)
                 : (c[0] ? (c >> 1) ^ CRC_POLY_LSB : c >> 1);
    end
    return c;
  endfunction
  task automatic tally_and_finish();
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k = 1);
    repeat (k) @(negedge clk);
  endtask
  task automatic strobe(ref logic s);
    s = 1'b1;
    cyc();
    s = 1'b0;
    cyc();
  endtask
  task automatic flags(input logic [7:0] s, input logic [7:0] c);
    {irq_flag_set, irq_flag_clr} = {s, c};
    cyc();
    {irq_flag_set, irq_flag_clr} = 16'h0000;
    cyc();
  endtask
  task automatic chk_q();
    chk(16'(queue_fill_count), 16'(q.size()));
    chk(16'(queue_nearly_full), 16'(64 - q.size() <= queue_threshold));
    chk(16'(queue_nearly_empty), 16'(q.size() <= queue_threshold));
  endtask
  task automatic push(input logic [7:0] d);
    host_wdata = d;
    strobe(host_wr);
    if (q.size() < 64) q.push_back(d);
    chk_q();
  endtask
  task automatic pop(input logic e);
    if (e) strobe(eng_rd);
    else strobe(host_rd);
    if (q.size() > 0) begin
      last = q.pop_front();
      chk(16'(e ? eng_rdata : host_rdata), 16'(last));
    end
    chk_q();
  endtask
  initial begin
    {host_wr, host_rd, queue_clear, eng_rd, len_check_en, tx_eof_start, crc_high_bit_leading,
     tick_divider_even, tick_periodic, tick_go, tick_halt, tick_auto_launch, rx_go, nrst} = '0;
    {host_wdata, error_flags, irq_flag_set, irq_flag_clr, rx_len, cmd_select, crc_seed_sel,
     tick_divider, tick_reload_value, queue_threshold, frame_len_floor, frame_len_ceiling} = '0;
    irq_enable_mask = 8'(rnd());
    cyc(10);
    nrst = 1'b1;
    queue_threshold = 6'(rnd());
    cyc(2);
    for (int i = 0; i < 65; i++) push(8'(rnd()));
    chk(16'(queue_overrun), 16'h0001);
    for (int i = 0; i < 65; i++) pop(!i[0]);
    chk(16'(host_rdata), 16'(last));
    chk(16'({queue_overrun, irq_flags[6:5]}), 16'h0007);
    strobe(queue_clear);
    chk(16'({queue_overrun, queue_fill_count}), 16'h0000);
    for (int i = 0; i < 12; i++) begin
      {frame_len_floor, frame_len_ceiling, rx_len} = (i < 7) ? tbl[i] : 20'(rnd());
      len_check_en = (i != 6);
      flags(8'h00, 8'hFF);
      strobe(rx_go);
      for (n = 0; n < 9 && rx_busy; n++) cyc();
      cyc(2);
      ok = !len_check_en || (rx_len >= frame_len_floor * 4
           && (frame_len_ceiling == 0 || rx_len < frame_len_ceiling * 4));
      chk(16'(queue_fill_count), ok ? 16'h0003 : 16'h0000);
      chk(16'(irq_flags[IRQ_RECV]), 16'(ok));
      strobe(queue_clear);
    end
    for (int s = 0; s < 8; s++) begin
      {crc_high_bit_leading, crc_seed_sel} = 3'(s);
      d0 = 8'(rnd());
      d1 = 8'(rnd());
      push(d0);
      push(d1);
      cmd_select = CMD_CALC_CRC;
      // Complete stays high from the last run until this start clears it
      cyc();
      for (n = 0; n < 20 && !checksum_complete; n++) cyc();
      cyc(2);
      chk({crc_result_hi, crc_result_lo}, crcf(3'(s), d0, d1));
      chk(16'({irq_flags[IRQ_CRC], queue_fill_count}), 16'h0080);
      cmd_select = CMD_IDLE;
      cyc(2);
      chk(16'(irq_flags[IRQ_CMD]), 16'h0001);
      flags(8'h00, 8'hFF);
      chk(16'({irq_any, irq_flags}), 16'h0000);
      q.delete();
    end
    tick_divider = 12'h004;
    tick_reload_value = 16'h0003;
    for (int e = 0; e < 2; e++) begin
      tick_divider_even = e[0];
      strobe(tick_go);
      for (n = 2; n < 400 && !irq_flags[IRQ_TIMER]; n++) cyc();
      want = 3 * (9 + e) * 4000 / 1356;
      chk(16'(n >= want - 4 && n <= want + 4), 16'h0001);
      for (n = 0; n < 60 && tick_active; n++) cyc();
      chk(16'(tick_active), 16'h0000);
      chk(tick_current_count, 16'h0000);
      flags(8'h00, 8'h01);
      chk(16'(irq_flags[IRQ_TIMER]), 16'h0000);
    end
    flags(8'h01, 8'h00);
    chk(16'(irq_flags[IRQ_TIMER]), 16'h0001);
    tick_periodic = 1'b1;
    strobe(tick_go);
    cyc(150);
    chk(16'(tick_active), 16'h0001);
    strobe(tick_halt);
    chk(16'(tick_active), 16'h0000);
    tick_auto_launch = 1'b1;
    strobe(tx_eof_start);
    chk(16'({tick_active, irq_flags[IRQ_SEND]}), 16'h0003);
    error_flags = 8'(rnd()) | 8'h01;
    cyc(2);
    chk(16'(irq_flags[IRQ_FAULT]), 16'h0001);
    chk(16'(irq_any), 16'h0001);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("mismatch at %0t: run did not finish", $time);
    tally_and_finish();
  end
endmodule

/* File: dv/hfct_core_chk.sv */
// Port-level checks on the host data core: queue, length floor (short frames only), flags, timer.
// Bound to the core; one clock with a synchronous active-low reset.
module hfct_core_chk
  import hfct_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        host_wr,
  input wire logic        host_rd,
  input wire logic        eng_rd,
  input wire logic        queue_clear,
  input wire logic [5:0]  queue_threshold,
  input wire logic [6:0]  queue_fill_count,
  input wire logic        queue_overrun,
  input wire logic        queue_nearly_full,
  input wire logic        queue_nearly_empty,
  input wire logic        rx_byte_valid,
  input wire logic        rx_byte_first,
  input wire logic [7:0]  rx_byte,
  input wire logic        len_check_en,
  input wire logic [5:0]  frame_len_floor,
  input wire logic        len_reject,
  input wire logic        tx_eof_start,
  input wire logic [7:0]  error_flags,
  input wire logic [3:0]  cmd_select,
  input wire logic        checksum_complete,
  input wire logic [7:0]  irq_enable_mask,
  input wire logic [7:0]  irq_flags,
  input wire logic        irq_out,
  input wire logic        tick_go,
  input wire logic        tick_halt,
  input wire logic [15:0] tick_reload_value,
  input wire logic [15:0] tick_current_count,
  input wire logic        tick_active
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic quiet;
  // Other queue traffic is excluded so a push alone must move the count
  assign quiet = !host_rd && !eng_rd && !queue_clear && !rx_byte_valid
                 && cmd_select != CMD_CALC_CRC;
  AST_FILL_PUSH: assert property (host_wr && quiet && queue_fill_count < FIFO_DEPTH
    |=> queue_fill_count == $past(queue_fill_count) + 7'h01) else $error("push count");
  AST_OVR_SET: assert property (host_wr && quiet && queue_fill_count == FIFO_DEPTH
    |=> queue_overrun && queue_fill_count == FIFO_DEPTH) else $error("overrun set");
  AST_CLEAR: assert property (queue_clear && !host_wr && !rx_byte_valid
    |=> queue_fill_count == 7'h00 && !queue_overrun) else $error("clear");
  AST_OVR_HOLD: assert property (queue_overrun && !queue_clear |=> queue_overrun)
    else $error("overrun dropped");
  AST_NFULL: assert property ($stable(queue_threshold)
    |-> queue_nearly_full == (FIFO_DEPTH - queue_fill_count <= {1'b0, queue_threshold}))
    else $error("nearly full");
  AST_NEMPTY: assert property ($stable(queue_threshold)
    |-> queue_nearly_empty == (queue_fill_count <= {1'b0, queue_threshold}))
    else $error("nearly empty");
  // The pin is registered from the same next flags, so it moves with them
  AST_IRQ_PIN: assert property ($past(nrst)
    |-> irq_out == |(irq_flags & $past(irq_enable_mask)))
    else $error("irq pin");
  AST_FAULT: assert property (|error_flags |=> irq_flags[IRQ_FAULT])
    else $error("fault flag");
  AST_SEND: assert property (tx_eof_start |=> irq_flags[IRQ_SEND])
    else $error("send flag");
  AST_REJECT: assert property (rx_byte_valid && rx_byte_first && len_check_en
    && rx_byte < {frame_len_floor, 2'b00} |=> len_reject) else $error("short frame");
  AST_TICK_GO: assert property (tick_go && !tick_halt
    |=> tick_active && tick_current_count == $past(tick_reload_value)) else $error("go");
  AST_TICK_FLAG: assert property ($past(nrst) && $past(tick_current_count) == 16'h0001
    && tick_current_count == 16'h0000 |-> ##[0:2] irq_flags[IRQ_TIMER])
    else $error("timer flag");
  C_OVERRUN: cover property ($rose(queue_overrun));
  C_REJECT: cover property (len_reject);
  C_CRC: cover property ($rose(checksum_complete));
endmodule

bind hfct_core hfct_core_chk hfct_core_chk_i (.*);

/* File: dv/hfct_rx_model.sv */
// Receive-side model: one length-prefixed frame of three bytes per go.
// Sampled on the rising edge, where busy also rises; the bytes and frame end are driven on the falling edge.
module hfct_rx_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] len,
  output logic            rx_byte_valid,
  output logic            rx_byte_first,
  output logic      [7:0] rx_byte,
  output logic            rx_frame_end,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {rx_byte_valid, rx_byte_first, rx_frame_end, busy} = 4'h0;
    rx_byte = 8'h00;
    forever begin
      @(posedge clk);
      if (go) begin
        busy = 1'b1;
        for (int i = 0; i < 3; i++) begin
          @(negedge clk);
          rx_byte_valid = 1'b1;
          rx_byte_first = (i == 0);
          rx_byte = (i == 0) ? len : len ^ 8'(i);
        end
        @(negedge clk);
        {rx_byte_valid, rx_byte_first, rx_frame_end} = 3'h1;
        // Released data shows the inverse, never a stale byte
        rx_byte = ~rx_byte;
        @(negedge clk);
        {rx_frame_end, busy} = 2'h0;
      end
    end
  end
endmodule

/* File: hw/hfct_core.sv */
// Top of the host data core: shared byte queue, frame length window,
// interrupt flags and the glue to the CRC and timer units.
// Host strobes and internal engine signals are on this clock; none are
// synchronised. Host and engine must not fight over the queue.
module hfct_core
  import hfct_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        host_wr,
  input  wire logic [7:0]  host_wdata,
  input  wire logic        host_rd,
  output logic      [7:0]  host_rdata,
  input  wire logic        queue_clear,
  input  wire logic [5:0]  queue_threshold,
  output logic      [6:0]  queue_fill_count,
  output logic             queue_overrun,
  output logic             queue_nearly_full,
  output logic             queue_nearly_empty,
  input  wire logic        eng_rd,
  output logic      [7:0]  eng_rdata,
  input  wire logic        rx_byte_valid,
  input  wire logic        rx_byte_first,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_frame_end,
  input  wire logic        len_check_en,
  input  wire logic [5:0]  frame_len_floor,
  input  wire logic [5:0]  frame_len_ceiling,
  output logic             len_reject,
  input  wire logic        tx_eof_start,
  input  wire logic [7:0]  error_flags,
  input  wire logic [3:0]  cmd_select,
  input  wire logic [1:0]  crc_seed_sel,
  input  wire logic        crc_high_bit_leading,
  output logic      [7:0]  crc_result_hi,
  output logic      [7:0]  crc_result_lo,
  output logic             checksum_complete,
  input  wire logic [7:0]  irq_enable_mask,
  input  wire logic [7:0]  irq_flag_set,
  input  wire logic [7:0]  irq_flag_clr,
  output logic      [7:0]  irq_flags,
  output logic             irq_any,
  output logic             irq_out,
  input  wire logic [11:0] tick_divider,
  input  wire logic        tick_divider_even,
  input  wire logic [15:0] tick_reload_value,
  input  wire logic        tick_periodic,
  input  wire logic        tick_go,
  input  wire logic        tick_halt,
  input  wire logic        tick_auto_launch,
  output logic      [15:0] tick_current_count,
  output logic             tick_active
);
  typedef struct packed {
    logic [63:0][7:0] mem;
    logic [5:0]       wp;
    logic [5:0]       rp;
    logic [6:0]       lvl;
    logic             ovf;
    logic [7:0]       hrdata;
    logic [7:0]       erdata;
    logic             nfull;
    logic             nempty;
    logic [7:0]       irq;
    logic             irq_all;
    logic             irq_pin;
    logic             frame_ok;
    logic             len_rej;
    logic             crc_busy;
    logic             crc_rdy;
    logic [3:0]       cmd_q;
    logic [7:0]       crc_hi;
    logic [7:0]       crc_lo;
  } hfct_core_st_t;

  hfct_core_st_t q_r;
  hfct_core_st_t q_nxt;

  hfct_sub_if sub ();

  logic [2:0]  pop_req;
  logic [2:0]  pop_ok;
  logic [2:0][7:0] pop_dat;
  logic [1:0]  push_req;
  logic [1:0][7:0] push_dat;
  logic [7:0]  irq_evt;
  logic        crc_go;
  logic        first_ok;
  logic [7:0]  len_lo;
  logic [7:0]  len_hi;

  hfct_crc u_crc (
    .clk  (clk),
    .nrst (nrst),
    .sub  (sub.crc_mp)
  );

  hfct_timer u_timer (
    .clk  (clk),
    .nrst (nrst),
    .sub  (sub.tmr_mp)
  );

  assign sub.crc_seed_sel = crc_seed_sel;
  assign sub.crc_msb      = crc_high_bit_leading;
  assign sub.crc_start    = crc_go;
  assign sub.crc_v        = pop_ok[2];
  assign sub.crc_d        = pop_dat[2];
  assign sub.tmr_div      = tick_divider;
  assign sub.tmr_even     = tick_divider_even;
  assign sub.tmr_reload   = tick_reload_value;
  assign sub.tmr_periodic = tick_periodic;
  assign sub.tmr_go       = tick_go;
  assign sub.tmr_halt     = tick_halt;
  assign sub.tmr_auto     = tick_auto_launch;
  // End of frame transmission is the protocol event that arms the timer
  assign sub.tmr_evt      = tx_eof_start;

  always_comb begin
    q_nxt    = q_r;
    pop_ok   = 3'b000;
    pop_dat  = '0;
    irq_evt  = 8'h00;
    q_nxt.len_rej = 1'b0;
    q_nxt.cmd_q   = cmd_select;

    // Length window: floor*4 <= len < ceiling*4, ceiling 0 opens to 256
    len_lo   = {frame_len_floor, 2'b00};
    len_hi   = {frame_len_ceiling, 2'b00};
    first_ok = !len_check_en ||
               ((rx_byte >= len_lo) &&
                ((frame_len_ceiling == 6'h00) || (rx_byte < len_hi)));

    // CRC run starts when the command field enters the CRC code
    crc_go = (cmd_select == CMD_CALC_CRC) && (q_r.cmd_q != CMD_CALC_CRC);
    if (crc_go) begin
      q_nxt.crc_busy = 1'b1;
      q_nxt.crc_rdy  = 1'b0;
    end else if (cmd_select != CMD_CALC_CRC) begin
      q_nxt.crc_busy = 1'b0;
    end

    // Clear acts first so that traffic in the same cycle lands afterwards
    if (queue_clear) begin
      q_nxt.wp  = 6'h00;
      q_nxt.rp  = 6'h00;
      q_nxt.lvl = 7'h00;
      q_nxt.ovf = 1'b0;
    end

    pop_req = {q_r.crc_busy && !crc_go, eng_rd, host_rd};
    for (int i = 0; i < 3; i++) begin
      if (pop_req[i] && (q_nxt.lvl != 7'h00)) begin
        pop_ok[i]  = 1'b1;
        pop_dat[i] = q_nxt.mem[q_nxt.rp];
        q_nxt.rp   = q_nxt.rp + 6'h01;
        q_nxt.lvl  = q_nxt.lvl - 7'h01;
      end
    end
    if (pop_ok[0]) q_nxt.hrdata = pop_dat[0];
    if (pop_ok[1]) q_nxt.erdata = pop_dat[1];

    // The accept decision is taken on the length byte and held for the frame
    if (rx_byte_valid && rx_byte_first) begin
      q_nxt.frame_ok = first_ok;
      q_nxt.len_rej  = !first_ok;
    end
    push_req = {rx_byte_valid && (rx_byte_first ? first_ok : q_r.frame_ok), host_wr};
    push_dat = {rx_byte, host_wdata};
    for (int i = 0; i < 2; i++) begin
      if (push_req[i]) begin
        if (q_nxt.lvl == FIFO_DEPTH) begin
          q_nxt.ovf = 1'b1;
        end else begin
          q_nxt.mem[q_nxt.wp] = push_dat[i];
          q_nxt.wp  = q_nxt.wp + 6'h01;
          q_nxt.lvl = q_nxt.lvl + 7'h01;
        end
      end
    end

    // CRC has drained the queue once nothing is left after this cycle
    if (q_r.crc_busy && !crc_go && (q_nxt.lvl == 7'h00)) begin
      q_nxt.crc_busy = 1'b0;
      q_nxt.crc_rdy  = 1'b1;
      irq_evt[IRQ_CRC] = 1'b1;
    end

    q_nxt.nfull  = ((FIFO_DEPTH - q_nxt.lvl) <= {1'b0, queue_threshold});
    q_nxt.nempty = (q_nxt.lvl <= {1'b0, queue_threshold});

    irq_evt[IRQ_TIMER]  = sub.tmr_expire;
    irq_evt[IRQ_SEND]   = tx_eof_start;
    // A rejected frame raises no receive flag since it never happened for the host
    irq_evt[IRQ_RECV]   = rx_frame_end && q_r.frame_ok;
    irq_evt[IRQ_CMD]    = (cmd_select == CMD_IDLE) && (q_r.cmd_q != CMD_IDLE);
    irq_evt[IRQ_FAULT]  = (|error_flags) || q_nxt.ovf;
    irq_evt[IRQ_NFULL]  = q_nxt.nfull && !q_r.nfull;
    irq_evt[IRQ_NEMPTY] = q_nxt.nempty && !q_r.nempty;

    // Hardware events win over a host clear in the same cycle
    q_nxt.irq     = (q_r.irq & ~irq_flag_clr) | irq_flag_set | irq_evt;
    q_nxt.irq_all = |q_nxt.irq;
    q_nxt.irq_pin = |(q_nxt.irq & irq_enable_mask);

    q_nxt.crc_hi = sub.crc_val[15:8];
    q_nxt.crc_lo = sub.crc_val[7:0];
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q_r          <= '0;
      q_r.nempty   <= 1'b1;
      q_r.frame_ok <= 1'b1;
      q_r.irq      <= IRQ_RST;
      q_r.cmd_q    <= CMD_IDLE;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign host_rdata         = q_r.hrdata;
  assign eng_rdata          = q_r.erdata;
  assign queue_fill_count   = q_r.lvl;
  assign queue_overrun      = q_r.ovf;
  assign queue_nearly_full  = q_r.nfull;
  assign queue_nearly_empty = q_r.nempty;
  assign len_reject         = q_r.len_rej;
  assign crc_result_hi      = q_r.crc_hi;
  assign crc_result_lo      = q_r.crc_lo;
  assign checksum_complete  = q_r.crc_rdy;
  assign irq_flags          = q_r.irq;
  assign irq_any            = q_r.irq_all;
  assign irq_out            = q_r.irq_pin;
  assign tick_current_count = sub.tmr_count;
  assign tick_active        = sub.tmr_active;
endmodule

/* File: hw/hfct_crc.sv */
// Byte-wide CRC coprocessor, one byte per clock.
// Assumes the core pulses crc_start before the first byte.
module hfct_crc
  import hfct_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  hfct_sub_if.crc_mp sub
);
  typedef struct packed {
    logic [15:0] crc;
  } hfct_crc_st_t;

  hfct_crc_st_t q_r;
  hfct_crc_st_t q_nxt;
  logic         fb;

  always_comb begin
    q_nxt = q_r;
    fb    = 1'b0;
    if (sub.crc_start) begin
      case (sub.crc_seed_sel)
        2'b00:   q_nxt.crc = CRC_SEED_0;
        2'b01:   q_nxt.crc = CRC_SEED_1;
        2'b10:   q_nxt.crc = CRC_SEED_2;
        default: q_nxt.crc = CRC_SEED_3;
      endcase
    end else if (sub.crc_v) begin
      for (int i = 0; i < 8; i++) begin
        if (sub.crc_msb) begin
          fb        = q_nxt.crc[15] ^ sub.crc_d[7 - i];
          q_nxt.crc = {q_nxt.crc[14:0], 1'b0} ^ (fb ? CRC_POLY_MSB : 16'h0000);
        end else begin
          fb        = q_nxt.crc[0] ^ sub.crc_d[i];
          q_nxt.crc = {1'b0, q_nxt.crc[15:1]} ^ (fb ? CRC_POLY_LSB : 16'h0000);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) q_r <= '0;
    else       q_r <= q_nxt;
  end

  assign sub.crc_val = q_r.crc;
endmodule

/* File: hw/hfct_pkg.sv */
// Constants shared by the host FIFO, CRC and timer core.
// Assumes one 40 MHz clock with a synchronous active-low reset.
package hfct_pkg;
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          TMR_HZ        = 13_560_000;
  localparam int          RATE_GCD      = 10_000;
  localparam logic [12:0] TMR_ACC_INC   = 13'(TMR_HZ / RATE_GCD);
  localparam logic [12:0] TMR_ACC_MOD   = 13'(CLK_HZ / RATE_GCD);
  localparam logic [6:0]  FIFO_DEPTH    = 7'h40;
  localparam logic [7:0]  LEN_UNIT_SH   = 8'h02;
  localparam logic [15:0] CRC_SEED_0    = 16'h0000;
  localparam logic [15:0] CRC_SEED_1    = 16'h6363;
  localparam logic [15:0] CRC_SEED_2    = 16'hA671;
  localparam logic [15:0] CRC_SEED_3    = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_MSB  = 16'h1021;
  localparam logic [15:0] CRC_POLY_LSB  = 16'h8408;
  localparam logic [3:0]  CMD_IDLE      = 4'h0;
  localparam logic [3:0]  CMD_CALC_CRC  = 4'h3;
  localparam int          IRQ_TIMER     = 0;
  localparam int          IRQ_SEND      = 1;
  localparam int          IRQ_RECV      = 2;
  localparam int          IRQ_CMD       = 3;
  localparam int          IRQ_FAULT     = 4;
  localparam int          IRQ_NFULL     = 5;
  localparam int          IRQ_NEMPTY    = 6;
  localparam int          IRQ_CRC       = 7;
  localparam logic [7:0]  IRQ_RST       = 8'h00;
endpackage

/* File: hw/hfct_sub_if.sv */
// Carrier between the core and its CRC and timer units.
// All signals belong to the single core clock.
interface hfct_sub_if;
  logic        crc_start;
  logic [1:0]  crc_seed_sel;
  logic        crc_msb;
  logic        crc_v;
  logic [7:0]  crc_d;
  logic [15:0] crc_val;
  logic [11:0] tmr_div;
  logic        tmr_even;
  logic [15:0] tmr_reload;
  logic        tmr_periodic;
  logic        tmr_go;
  logic        tmr_halt;
  logic        tmr_auto;
  logic        tmr_evt;
  logic [15:0] tmr_count;
  logic        tmr_active;
  logic        tmr_expire;
  modport core_mp (output crc_start, crc_seed_sel, crc_msb, crc_v, crc_d, tmr_div, tmr_even,
                   tmr_reload, tmr_periodic, tmr_go, tmr_halt, tmr_auto, tmr_evt,
                   input crc_val, tmr_count, tmr_active, tmr_expire);
  modport crc_mp (input crc_start, crc_seed_sel, crc_msb, crc_v, crc_d, output crc_val);
  modport tmr_mp (input tmr_div, tmr_even, tmr_reload, tmr_periodic, tmr_go, tmr_halt,
                  tmr_auto, tmr_evt, output tmr_count, tmr_active, tmr_expire);
endinterface

/* File: hw/hfct_timer.sv */
// Prescaler and reload counter, advanced at an average 13.56 MHz rate.
// The tick is a fractional enable from the 40 MHz clock, so single
// ticks jitter by one clock; the long-run rate is exact.
module hfct_timer
  import hfct_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  hfct_sub_if.tmr_mp sub
);
  typedef struct packed {
    logic [12:0] acc;
    logic [12:0] pre;
    logic [15:0] cnt;
    logic        run;
    logic        exp;
  } hfct_tmr_st_t;

  hfct_tmr_st_t q_r;
  hfct_tmr_st_t q_nxt;
  logic [12:0]  sum;
  logic         tick;
  logic [12:0]  pre_top;

  always_comb begin
    q_nxt   = q_r;
    q_nxt.exp = 1'b0;
    sum     = q_r.acc + TMR_ACC_INC;
    tick    = (sum >= TMR_ACC_MOD);
    q_nxt.acc = tick ? (sum - TMR_ACC_MOD) : sum;
    // Period 2P+1, or 2P+2 with the even option
    pre_top = {sub.tmr_div, 1'b0} + {12'h000, sub.tmr_even};
    if (sub.tmr_go || (sub.tmr_auto && sub.tmr_evt)) begin
      q_nxt.run = 1'b1;
      q_nxt.pre = pre_top;
      q_nxt.cnt = sub.tmr_reload;
    end else if (sub.tmr_halt) begin
      q_nxt.run = 1'b0;
    end else if (q_r.run && tick) begin
      if (q_r.pre == 13'h0000) begin
        q_nxt.pre = pre_top;
        if (q_r.cnt == 16'h0000) begin
          if (sub.tmr_periodic) q_nxt.cnt = sub.tmr_reload;
          else                  q_nxt.run = 1'b0;
        end else begin
          q_nxt.exp = (q_r.cnt == 16'h0001);
          q_nxt.cnt = q_r.cnt - 16'h0001;
        end
      end else begin
        q_nxt.pre = q_r.pre - 13'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) q_r <= '0;
    else       q_r <= q_nxt;
  end

  assign sub.tmr_count  = q_r.cnt;
  assign sub.tmr_active = q_r.run;
  assign sub.tmr_expire = q_r.exp;
endmodule
